// ---- hw/tmc_timer.sv ----
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1: bit 15 set starts the 16-bit timer, cleared stops it.
// RL2: bit 13 set halts the timer during Idle; clear keeps it running.
// RL3: extended select 10 low-power RC, 01 external pin, 00 secondary oscillator; 11 reserved.
// RL4: extended select matters only when clock source select is one.
// RL5: bit 6 enables gated accumulation only with the internal clock selected.
// RL6: prescale 11 divides 256, 10 by 64, 01 by 8, 00 by 1.
// RL7: bit 2 synchronises external input when external source selected; else ignored.
// RL8: bit 1 one takes extended source; zero takes internal Fosc/2.
// RL9: bits 14, 12-10, 7, 3, 0 read zero and ignore writes.
// RL10: any reset clears the control register to the same value.
// RL11: enabled timer increments count per prescaled tick, wrapping at maximum.
// RL12: gated mode counts internal ticks only while the gate input is high.
module tmc_timer
    import tmc_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire tmc_srcs_t   clkSources,
    input  wire logic        gateIn,
    input  wire logic        idleMode,
    output logic [CNT_WIDTH-1:0] countValue
);
    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic [15:0]          control_q;
    logic [CNT_WIDTH-1:0] count_q;
    logic                 ack_q;
    logic                 wrCtl;
    logic                 wrCnt;
    logic [15:0]          wdata16;
    tmc_ctrl_t            ctl;
    logic                 countActive;

    // one wait cycle per access keeps read data registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    assign wdata16 = avs_writedata[15:0];
    assign wrCtl   = avs_write & ack_q & (avs_address == ADDR_CONTROL);
    assign wrCnt   = avs_write & ack_q & (avs_address == ADDR_COUNT);

    function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                              input logic [15:0] nw,
                                              input logic [1:0]  be);
        laneMerge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction : laneMerge

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            control_q <= CONTROL_RESET; // [RL10]
        end else if (wrCtl) begin
            control_q <= laneMerge(control_q, wdata16, avs_byteenable[1:0]) & CONTROL_MASK; // [RL9]
        end
    end

    assign ctl.run        = control_q[POS_RUN];
    assign ctl.haltInIdle = control_q[POS_HALTI];
    assign ctl.extSel     = tmc_ext_t'(control_q[POS_EXTLO+:2]);
    assign ctl.gateEn     = control_q[POS_GATE];
    assign ctl.prescale   = control_q[POS_PSLO+:2];
    assign ctl.syncEn     = control_q[POS_SYNC];
    assign ctl.srcSel     = control_q[POS_CSRC];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack_q) begin
            case (avs_address)
                ADDR_CONTROL: avs_readdata <= {16'h0000, control_q};
                ADDR_COUNT:   avs_readdata <= 32'(count_q);
                ADDR_STATUS:  avs_readdata <= {29'h0, countActive, idleMode, gateIn};
                default:      avs_readdata <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // clock source selection
    // ----------------------------------------------------------------
    logic extRaw;
    logic extTick;
    logic intTick;
    logic rawTick;
    logic gatedTick;
    logic psTick;

    always_comb begin
        case (ctl.extSel) // [RL3]
            EXT_LOW_RC:  extRaw = clkSources.lowPowerRc;
            EXT_PIN:     extRaw = clkSources.extPin;
            EXT_SEC_OSC: extRaw = clkSources.secOsc;
            default:  extRaw = 1'b0; // reserved code gives no clock
        endcase
    end

    // unsynchronised mode still samples on clk_sys; only the two-flop delay is skipped
    tmc_edge_detect u_ext_edge (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .srcIn     (extRaw),
        .syncEn    (ctl.syncEn), // [RL7]
        .risePulse (extTick)
    );

    // instruction clock: every other system clock cycle
    logic halfPhase_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            halfPhase_q <= 1'b0;
        end else begin
            halfPhase_q <= ~halfPhase_q;
        end
    end
    assign intTick = halfPhase_q;

    assign rawTick   = ctl.srcSel ? extTick : intTick; // [RL8] [RL4]
    assign gatedTick = (!ctl.srcSel && ctl.gateEn) ? (intTick & gateIn) : rawTick; // [RL5] [RL12]
    assign countActive = ctl.run & ~(ctl.haltInIdle & idleMode); // [RL1] [RL2]

    tmc_prescaler u_ps (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .tickIn   (gatedTick & countActive),
        .clear    (~ctl.run),
        .prescale (ctl.prescale),
        .tickOut  (psTick)
    );

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= CNT_WIDTH'(COUNT_RESET);
        end else if (wrCnt) begin
            count_q <= CNT_WIDTH'(laneMerge(16'(count_q), wdata16, avs_byteenable[1:0]));
        end else if (psTick) begin
            count_q <= count_q + CNT_WIDTH'(1); // [RL11]
        end
    end

    assign countValue = count_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_RUN_STOP: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL1]
        (!ctl.run && !wrCnt) |=> $stable(count_q))
        else $error("count moved while stopped");
    AST_IDLE_HALT: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL2]
        (ctl.haltInIdle && idleMode && !wrCnt) |=> $stable(count_q))
        else $error("count moved in idle halt");
    AST_RESERVED_EXT: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL3]
        (ctl.extSel == EXT_RSVD) |-> (extRaw == 1'b0))
        else $error("reserved source not silent");
    AST_INT_IGNORES_EXT: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL4]
        (!ctl.srcSel && !ctl.gateEn) |-> (rawTick == halfPhase_q))
        else $error("extended select leaked");
    AST_GATE_LOW: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL12]
        (!ctl.srcSel && ctl.gateEn && !gateIn) |-> !gatedTick)
        else $error("gated tick without gate");
    AST_GATE_IGNORED: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL5]
        ctl.srcSel |-> (gatedTick == extTick))
        else $error("gate not ignored on external");
    AST_DIV1: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL6]
        (ctl.prescale == 2'b00 && gatedTick && countActive) |-> psTick)
        else $error("1:1 prescale missed a tick");
    AST_UNIMPL_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL9]
        (control_q & ~CONTROL_MASK) == 16'h0000)
        else $error("unimplemented bit set");
    AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL11]
        (psTick && !wrCnt && count_q == '1) |=> (count_q == '0))
        else $error("count did not wrap");
    AST_SRC_SEL: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL8]
        ctl.srcSel |-> (rawTick == extTick))
        else $error("extended source not used");
    AST_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_b) // [RL7]
        (ctl.syncEn && !extRaw ##1 extRaw && ctl.syncEn ##1 ctl.syncEn ##1 ctl.syncEn)
        |-> extTick)
        else $error("synchronised edge late");
    AST_RESET_CTL: assert property (@(posedge clk_sys) // [RL10]
        !rst_b |-> (control_q == CONTROL_RESET))
        else $error("control not reset");
endmodule : tmc_timer
`default_nettype wire

// ---- hw/tmc_pkg.sv ----
package tmc_pkg;
    // register map (byte addresses, one aligned 32-bit word each)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_COUNT   = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h8;

    // control field positions
    localparam int POS_RUN   = 15;
    localparam int POS_HALTI = 13;
    localparam int POS_EXTLO = 8;
    localparam int POS_GATE  = 6;
    localparam int POS_PSLO  = 4;
    localparam int POS_SYNC  = 2;
    localparam int POS_CSRC  = 1;

    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_MASK  = 16'ha376;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;

    // prescale terminal counts (divide minus one)
    localparam logic [7:0] PS_DIV1   = 8'h00;
    localparam logic [7:0] PS_DIV8   = 8'h07;
    localparam logic [7:0] PS_DIV64  = 8'h3f;
    localparam logic [7:0] PS_DIV256 = 8'hff;

    typedef enum logic [1:0] {
        EXT_SEC_OSC = 2'b00,
        EXT_PIN     = 2'b01,
        EXT_LOW_RC  = 2'b10,
        EXT_RSVD    = 2'b11
    } tmc_ext_t;

    typedef struct packed {
        logic       run;
        logic       haltInIdle;
        tmc_ext_t   extSel;
        logic       gateEn;
        logic [1:0] prescale;
        logic       syncEn;
        logic       srcSel;
    } tmc_ctrl_t;

    typedef struct packed {
        logic secOsc;
        logic lowPowerRc;
        logic extPin;
    } tmc_srcs_t;
endpackage : tmc_pkg

// ---- hw/tmc_edge_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
// rising-edge detector with optional two-flop synchroniser in front
module tmc_edge_detect
    import tmc_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic srcIn,
    input  wire logic syncEn,
    output logic      risePulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic sample;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= srcIn;
            sync_q <= meta_q;
        end
    end

    // unsynchronised path trades metastability margin for two cycles less latency
    assign sample = syncEn ? sync_q : srcIn;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sample;
        end
    end

    assign risePulse = sample & ~prev_q;
endmodule : tmc_edge_detect
`default_nettype wire

// ---- hw/tmc_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmc_prescaler
    import tmc_pkg::*;
#(
    parameter int PS_WIDTH = 8
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       tickIn,
    input  wire logic       clear,
    input  wire logic [1:0] prescale,
    output logic            tickOut
);
    logic [PS_WIDTH-1:0] psCnt_q;
    logic [PS_WIDTH-1:0] terminal;

    function automatic logic [PS_WIDTH-1:0] termOf(input logic [1:0] code);
        case (code)
            2'b11:   termOf = PS_WIDTH'(PS_DIV256);
            2'b10:   termOf = PS_WIDTH'(PS_DIV64);
            2'b01:   termOf = PS_WIDTH'(PS_DIV8);
            default: termOf = PS_WIDTH'(PS_DIV1);
        endcase
    endfunction : termOf

    assign terminal = termOf(prescale); // [RL6]
    assign tickOut  = tickIn & (psCnt_q >= terminal);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            psCnt_q <= '0;
        end else if (clear || tickOut) begin
            psCnt_q <= '0;
        end else if (tickIn) begin
            psCnt_q <= psCnt_q + PS_WIDTH'(1);
        end
    end
endmodule : tmc_prescaler
`default_nettype wire

// ---- tb/basic_sixteen_bit_timer_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module basic_sixteen_bit_timer_control_tb_top;
    import tmc_pkg::*;

    logic        clk_sys;
    logic        rst_b;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    tmc_srcs_t   clkSources;
    logic        gateIn;
    logic        idleMode;
    logic [15:0] countValue;
    logic [31:0] seed;
    logic [31:0] hit;
    logic [3:0]  srcCnt;
    logic [2:0]  srcVec;
    logic [31:0] expQ[$];
    int          selBit;
    int          n_mismatch = 0;
    int          comparisons = 0;

    tmc_timer u_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .clkSources(clkSources), .gateIn(gateIn),
        .idleMode(idleMode), .countValue(countValue)
    );

    // ----------------------------------------
    // clock and source stimulus
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    // unselected sources toggle randomly so a wrong mux choice shows up as extra counts
    always @(posedge clk_sys) begin
        seed   <= xs(seed);
        srcCnt <= srcCnt + 4'h1;
        srcVec = seed[2:0];
        if (selBit < 3) srcVec[selBit] = srcCnt[2];
        clkSources <= tmc_srcs_t'(srcVec);
    end

    // ----------------------------------------
    // read checker: oldest note against returned data
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            hit = expQ.pop_front();
            comparisons++;
            if (!(avs_readdata[31:16] === 16'h0000 && (avs_readdata[15:0] >= hit[31:16]) === 1'b1
                  && (avs_readdata[15:0] <= hit[15:0]) === 1'b1)) begin
                n_mismatch++;
                $display("mismatch at %0t: read %h expected %h..%h", $time,
                         avs_readdata, hit[31:16], hit[15:0]);
            end
            if (avs_address == ADDR_COUNT) begin
                comparisons++;
                if (!((countValue >= hit[31:16]) === 1'b1 && (countValue <= hit[15:0]) === 1'b1)) begin
                    n_mismatch++;
                    $display("mismatch at %0t: countValue %h", $time, countValue);
                end
            end
        end
    end

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                       input logic [3:0] be);
        avs_address    <= a;
        avs_writedata  <= {16'h0000, d};
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        @(posedge clk_sys);
        // only the watchdog ends a wait that never gets an answer
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [15:0] lo, input logic [15:0] hi);
        expQ.push_back({lo, hi});
        bus(1'b0, a, 16'h0000, 4'hf);
    endtask : rd

    // count from st for k cycles, stop, let 40 idle cycles pass, then read the count
    task automatic run(input logic [15:0] c, input logic [15:0] st, input int k,
                       input logic [15:0] lo, input logic [15:0] hi);
        bus(1'b1, ADDR_COUNT, st, 4'hf);
        bus(1'b1, ADDR_CONTROL, c, 4'hf);
        repeat (k) @(posedge clk_sys);
        bus(1'b1, ADDR_CONTROL, c & 16'h7fff, 4'hf);
        repeat (40) @(posedge clk_sys);
        rd(ADDR_COUNT, lo, hi);
    endtask : run

    task report_and_stop;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        clkSources = '0;
        gateIn = 1'b0;
        idleMode = 1'b0;
        seed = 32'hf407;
        srcCnt = 4'h0;
        selBit = 3;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(ADDR_CONTROL, 16'h0000, 16'h0000);
        bus(1'b1, ADDR_CONTROL, 16'hffff, 4'hf);
        rd(ADDR_CONTROL, 16'ha376, 16'ha376);
        bus(1'b1, ADDR_CONTROL, 16'h0000, 4'hf);
        bus(1'b1, ADDR_CONTROL, 16'hffff, 4'h2);
        rd(ADDR_CONTROL, 16'ha300, 16'ha300);
        bus(1'b1, 4'hc, 16'hffff, 4'hf);
        rd(4'hc, 16'h0000, 16'h0000);
        rd(ADDR_CONTROL, 16'ha300, 16'ha300);
        // stop the timer so the first run starts from a still counter
        bus(1'b1, ADDR_CONTROL, 16'h0000, 4'hf);
        // extended field set alongside prescale, but internal clock chosen
        for (int p = 0; p < 4; p++) begin
            run(16'h8000 | 16'(p << 4) | 16'(p << 8), 16'h0000,
                (p == 3) ? 8192 : (32 << (3 * p)), 16'd14, 16'd18);
        end
        // gate bit set while an external source is chosen, gate low
        for (int i = 0; i < 8; i++) begin
            selBit = (i[1:0] == 2'b00) ? 2 : (i[1:0] == 2'b01) ? 0 : (i[1:0] == 2'b10) ? 1 : 3;
            run(16'h8042 | 16'((i % 4) << 8) | 16'((i / 4) << 2), 16'h0000, 128,
                (i[1:0] == 2'b11) ? 16'd0 : 16'd14,
                (i[1:0] == 2'b11) ? 16'd0 : 16'd18);
        end
        selBit = 3;
        run(16'h8040, 16'h0000, 64, 16'd0, 16'd0);
        gateIn <= 1'b1;
        run(16'h8040, 16'h0000, 32, 16'd14, 16'd18);
        idleMode <= 1'b1;
        run(16'ha000, 16'h0000, 64, 16'd0, 16'd0);
        rd(ADDR_STATUS, 16'h0003, 16'h0003);
        run(16'h8000, 16'h0000, 32, 16'd14, 16'd18);
        idleMode <= 1'b0;
        run(16'h8000, 16'hfff8, 32, 16'd6, 16'd10);
        bus(1'b1, ADDR_CONTROL, 16'ha376, 4'hf);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(ADDR_CONTROL, 16'h0000, 16'h0000);
        rd(ADDR_COUNT, 16'h0000, 16'h0000);
        report_and_stop();
    end

    // expected run is near 13k cycles; the limit leaves ample margin
    initial begin
        #400000;
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : basic_sixteen_bit_timer_control_tb_top
`default_nettype wire
